/* File: rtl/smrp_pkg.sv */
// Package for the shared-memory read-protect block.
// Holds register offsets, field positions, reset values and block geometry.
package smrp_pkg;

    // Register offsets on the core register port
    localparam logic [15:0] ADDR_CTRL_STATUS = 16'hf900;
    localparam logic [15:0] ADDR_MAIN_TOP = 16'hf902;
    localparam logic [15:0] ADDR_SEMAPHORE = 16'hf904;
    localparam logic [15:0] ADDR_OVR_LOW = 16'hf910;
    localparam logic [15:0] ADDR_OVR_MID = 16'hf912;
    localparam logic [15:0] ADDR_OVR_HIGH = 16'hf914;

    // Field positions
    localparam int READ_ERR_BIT = 0;
    localparam int RESP_LSB = 3;
    localparam int RESP_MSB = 4;
    localparam int FLAG_WRITTEN_BIT = 6;
    localparam int SIZE_MSB = 4;
    localparam int HOST_FLAGS_MSB = 3;
    localparam int CORE_FLAGS_LSB = 4;
    localparam int CORE_FLAGS_MSB = 7;

    // Reset values
    localparam logic [7:0] SEM_RESET = 8'h00;
    localparam logic [1:0] RESP_RESET = 2'h0;
    localparam logic [4:0] SIZE_FORCED = 5'h00;
    localparam logic [4:0] SIZE_DEFAULT = 5'h02;

    // Block geometry
    localparam int LOW_BLOCK_BYTES = 32'h2000;
    localparam int BIG_BLOCK_BYTES = 32'h10000;
    localparam int LOW_COUNT = 16;
    localparam int REG_BITS = 16;
    localparam int OVR_BITS = 48;
    localparam int MID_RSVD = 2;
    localparam int LOW_SEVEN = 7;
    localparam logic [20:0] LOW_SPAN = 21'h020000;

    typedef enum logic [1:0] {
        RESP_LONG_WAIT,
        RESP_READ_ZERO,
        RESP_ERROR_SYNC,
        RESP_RESERVED
    } resp_e;

    typedef enum logic [1:0] {
        ENV_FIELD_RUN,
        ENV_ONBOARD_DEBUG,
        ENV_ENGINEERING,
        ENV_UNUSED
    } env_e;

endpackage

/* File: rtl/shared_memory_read_protect.sv */
// Shared-memory read protection: main block top, semaphores, read overrides.
// Assumes host-side strobes and protection-word values come from logic on clk;
// the environment strap comes from pins and is synchronised here.
//
// Notes on behaviour
// - Top register loads only on power-up reset
// - Top writable by core only in engineering
// - Size field times 64K gives top
// - Top is first address above block
// - Power-up size zero if forced, else flash
// - Semaphores clear to zero on reset
// - Low semaphore nibble written by host only
// - High semaphore nibble written by core only
// - Host read needs protect and override clear
// - Overrides reload on reset or top change
// - Low bits 8K blocks, others 64K
// - Low bit index times 8K gives range; others (index - 16) times 64K
// - Override one blocks read, zero defers
// - Low override bit seven always read-only
// - Reset: reserved 0, else core boot 1, host boot 0, others 1
// - Boot-block override bits read-only to core
// - Host boot range uses register top
// - Blocked read sets error flag, one clears
// - Blocked access answers per response field
// - Host semaphore write sets written flag
`timescale 1ns/100ps
`default_nettype none

module shared_memory_read_protect
    import smrp_pkg::*;
#(
    parameter logic [4:0] FLASH_UNITS = SIZE_DEFAULT
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic porRst,
    // Environment strap pins and protection word
    input wire logic [1:0] envPins,
    input wire logic forceTopZero,
    input wire logic [21:0] coreBootRegionSize,
    input wire logic [21:0] hostBootRegionSize,
    // Core register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Host semaphore access
    input wire logic hostSemWr,
    input wire logic [3:0] hostSemWrData,
    output logic [7:0] hostSemRdData,
    // Host read check
    input wire logic hostRdReq,
    input wire logic [20:0] hostRdAddr,
    input wire logic hostRdProtect,
    input wire logic hostAddrReserved,
    output logic hostRdDone,
    output logic hostRdAllowed,
    output logic hostRdLongWait,
    output logic hostRdZero,
    output logic hostRdErrSync,
    // Host write refusal from the write-protect side
    input wire logic hostWrReq,
    input wire logic hostWrBlocked,
    output logic hostWrDone,
    output logic hostWrIgnored,
    output logic hostWrErrSync,
    // Decoded main block top for the bridge
    output logic [21:0] mainBlockTopAddress
);

    logic [1:0] envMeta_ff;
    logic [1:0] envSync_ff;
    logic [4:0] mainBlockSizeUnits_ff;
    logic [4:0] sizeSeen_ff;
    logic [7:0] semaphoreReg_ff;
    logic [1:0] blockedAccessResponse_ff;
    logic hostReadErrorFlag_ff;
    logic hostFlagWritten_ff;
    logic [OVR_BITS-1:0] readOverride_ff;
    logic [OVR_BITS-1:0] nxt_readOverride;
    logic [OVR_BITS-1:0] ovrResetVal;
    logic [OVR_BITS-1:0] ovrReadOnly;
    logic [OVR_BITS-1:0] inCoreBoot;
    logic [OVR_BITS-1:0] inHostBoot;
    logic [15:0] regRdData_ff;
    logic [15:0] nxt_regRdData;
    logic [21:0] hostBootLow;
    logic [5:0] rdIndex;
    logic rdBlocked;
    logic reloadOverrides;
    logic wrTop;
    logic wrSem;
    logic wrCtrl;
    logic [1:0] wrOvrSel;
    logic wrOvr;
    resp_e respCode;

    // Strap pins cross into clk through two flops
    always_ff @(posedge clk) begin
        envMeta_ff <= envPins;
        envSync_ff <= envMeta_ff;
    end

    assign wrTop = regWr && (regAddr == ADDR_MAIN_TOP);
    assign wrSem = regWr && (regAddr == ADDR_SEMAPHORE);
    assign wrCtrl = regWr && (regAddr == ADDR_CTRL_STATUS);

    always_comb begin
        wrOvr = regWr;
        wrOvrSel = 2'h0;
        if (regAddr == ADDR_OVR_LOW) begin
            wrOvrSel = 2'h0;
        end else if (regAddr == ADDR_OVR_MID) begin
            wrOvrSel = 2'h1;
        end else if (regAddr == ADDR_OVR_HIGH) begin
            wrOvrSel = 2'h2;
        end else begin
            wrOvr = 1'b0;
        end
    end

    // Ordinary reset leaves the size alone; only power-up reloads it
    always_ff @(posedge clk) begin
        if (porRst) begin
            mainBlockSizeUnits_ff <= forceTopZero ? SIZE_FORCED : FLASH_UNITS;
        end else if (wrTop && env_e'(envSync_ff) == ENV_ENGINEERING) begin
            mainBlockSizeUnits_ff <= regWrData[SIZE_MSB:0];
        end
    end

    // First address past the main block, not its last byte
    assign mainBlockTopAddress = {1'b0, mainBlockSizeUnits_ff, 16'h0000};

    // Host boot range is measured from the register top, never an override
    assign hostBootLow = (hostBootRegionSize > mainBlockTopAddress) ? 22'h000000
                       : mainBlockTopAddress - hostBootRegionSize;

    for (genvar k = 0; k < OVR_BITS; k++) begin : g_blk
        localparam int J = k - LOW_COUNT;
        localparam int S = (k < LOW_COUNT) ? k * LOW_BLOCK_BYTES : J * BIG_BLOCK_BYTES;
        localparam int E = (k < LOW_COUNT) ? S + LOW_BLOCK_BYTES : S + BIG_BLOCK_BYTES;
        localparam bit RSVD = (J >= 0) && (J < MID_RSVD);
        assign inCoreBoot[k] = 22'(S) < coreBootRegionSize;
        assign inHostBoot[k] = !inCoreBoot[k] && (22'(E) > hostBootLow)
                             && (22'(S) < mainBlockTopAddress);
        assign ovrResetVal[k] = RSVD ? 1'b0 : (inCoreBoot[k] || !inHostBoot[k]);
        assign ovrReadOnly[k] = RSVD || inCoreBoot[k] || inHostBoot[k]
                              || (k == LOW_SEVEN);
    end

    // Reload follows any change of the top value one cycle later
    always_ff @(posedge clk) begin
        sizeSeen_ff <= mainBlockSizeUnits_ff;
    end

    assign reloadOverrides = rst || (sizeSeen_ff != mainBlockSizeUnits_ff);

    always_comb begin
        nxt_readOverride = readOverride_ff;
        if (reloadOverrides) begin
            nxt_readOverride = ovrResetVal;
        end else if (wrOvr) begin
            for (int b = 0; b < REG_BITS; b++) begin
                if (!ovrReadOnly[int'(wrOvrSel) * REG_BITS + b]) begin
                    nxt_readOverride[int'(wrOvrSel) * REG_BITS + b] = regWrData[b];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        readOverride_ff <= nxt_readOverride;
    end

    // Semaphore nibbles each have one writer
    always_ff @(posedge clk) begin
        if (rst) begin
            semaphoreReg_ff <= SEM_RESET;
        end else begin
            if (hostSemWr) begin
                semaphoreReg_ff[HOST_FLAGS_MSB:0] <= hostSemWrData;
            end
            if (wrSem) begin
                semaphoreReg_ff[CORE_FLAGS_MSB:CORE_FLAGS_LSB] <=
                    regWrData[CORE_FLAGS_MSB:CORE_FLAGS_LSB];
            end
        end
    end

    assign hostSemRdData = semaphoreReg_ff;

    // Host read lookup: low 128K uses 8K blocks, the rest 64K blocks
    assign rdIndex = (hostRdAddr < LOW_SPAN) ? {2'h0, hostRdAddr[16:13]}
                   : 6'(LOW_COUNT) + {1'b0, hostRdAddr[20:16]};
    assign rdBlocked = hostRdProtect || readOverride_ff[rdIndex]
                     || hostAddrReserved;
    assign respCode = resp_e'(blockedAccessResponse_ff);

    always_ff @(posedge clk) begin
        if (rst) begin
            blockedAccessResponse_ff <= RESP_RESET;
        end else if (wrCtrl) begin
            blockedAccessResponse_ff <= regWrData[RESP_MSB:RESP_LSB];
        end
    end

    // A new event in the clearing cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (rst) begin
            hostReadErrorFlag_ff <= 1'b0;
        end else if (hostRdReq && rdBlocked) begin
            hostReadErrorFlag_ff <= 1'b1;
        end else if (wrCtrl && regWrData[READ_ERR_BIT]) begin
            hostReadErrorFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hostFlagWritten_ff <= 1'b0;
        end else if (hostSemWr) begin
            hostFlagWritten_ff <= 1'b1;
        end else if (wrCtrl && regWrData[FLAG_WRITTEN_BIT]) begin
            hostFlagWritten_ff <= 1'b0;
        end
    end

    // Answers land one cycle after the request; reserved code refuses silently
    always_ff @(posedge clk) begin
        if (rst) begin
            hostRdDone <= 1'b0;
            hostRdAllowed <= 1'b0;
            hostRdLongWait <= 1'b0;
            hostRdZero <= 1'b0;
            hostRdErrSync <= 1'b0;
        end else begin
            hostRdDone <= hostRdReq;
            hostRdAllowed <= hostRdReq && !rdBlocked;
            hostRdLongWait <= hostRdReq && rdBlocked && respCode == RESP_LONG_WAIT;
            hostRdZero <= hostRdReq && rdBlocked && respCode == RESP_READ_ZERO;
            hostRdErrSync <= hostRdReq && rdBlocked && respCode == RESP_ERROR_SYNC;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hostWrDone <= 1'b0;
            hostWrIgnored <= 1'b0;
            hostWrErrSync <= 1'b0;
        end else begin
            hostWrDone <= hostWrReq;
            hostWrIgnored <= hostWrReq && hostWrBlocked && respCode != RESP_ERROR_SYNC;
            hostWrErrSync <= hostWrReq && hostWrBlocked && respCode == RESP_ERROR_SYNC;
        end
    end

    // Read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        nxt_regRdData = 16'h0000;
        unique case (regAddr)
            ADDR_CTRL_STATUS: begin
                nxt_regRdData[READ_ERR_BIT] = hostReadErrorFlag_ff;
                nxt_regRdData[RESP_MSB:RESP_LSB] = blockedAccessResponse_ff;
                nxt_regRdData[FLAG_WRITTEN_BIT] = hostFlagWritten_ff;
            end
            ADDR_MAIN_TOP: nxt_regRdData[SIZE_MSB:0] = mainBlockSizeUnits_ff;
            ADDR_SEMAPHORE: nxt_regRdData[7:0] = semaphoreReg_ff;
            ADDR_OVR_LOW: nxt_regRdData = readOverride_ff[15:0];
            ADDR_OVR_MID: nxt_regRdData = readOverride_ff[31:16];
            ADDR_OVR_HIGH: nxt_regRdData = readOverride_ff[47:32];
            default: nxt_regRdData = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData_ff <= 16'h0000;
        end else begin
            regRdData_ff <= regRd ? nxt_regRdData : 16'h0000;
        end
    end

    assign regRdData = regRdData_ff;

endmodule // shared_memory_read_protect

`default_nettype wire

/* File: bench/smrp_props.sv */
// Port assertions for the shared-memory read-protect block.
// Assumes rst is raised with porRst at power-up.
`timescale 1ns/100ps
`default_nettype none
module smrp_props (
    // Clock, resets, core port
    input wire logic clk,
    input wire logic rst,
    input wire logic porRst,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    // Host side
    input wire logic hostSemWr,
    input wire logic [3:0] hostSemWrData,
    input wire logic [7:0] hostSemRdData,
    input wire logic hostRdReq,
    input wire logic hostRdProtect,
    input wire logic hostAddrReserved,
    input wire logic hostRdDone,
    input wire logic hostRdAllowed,
    input wire logic [21:0] mainBlockTopAddress
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not zero when idle");
    a_host_rd_answer: assert property (hostRdReq |=> hostRdDone)
        else $error("host read not answered");
    a_done_has_cause: assert property (hostRdDone |-> $past(hostRdReq))
        else $error("host read answer without request");
    a_blocked_not_allowed: assert property ((hostRdReq && (hostRdProtect || hostAddrReserved))
        |=> !hostRdAllowed) else $error("protected read allowed");
    a_host_flags_take: assert property (hostSemWr |=> hostSemRdData[3:0] == $past(hostSemWrData))
        else $error("host flags not written");
    a_host_flags_keep: assert property (!hostSemWr |=> $stable(hostSemRdData[3:0]))
        else $error("host flags changed without host write");
    a_top_steady: assert property ((!porRst && !regWr) |=> $stable(mainBlockTopAddress))
        else $error("top address changed");
    a_top_units: assert property (mainBlockTopAddress[15:0] == 16'h0000
        && !mainBlockTopAddress[21]) else $error("top address not in 64K units");
endmodule // smrp_props
bind shared_memory_read_protect smrp_props props (.clk(clk), .rst(rst), .porRst(porRst),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .hostSemWr(hostSemWr),
    .hostSemWrData(hostSemWrData), .hostSemRdData(hostSemRdData), .hostRdReq(hostRdReq),
    .hostRdProtect(hostRdProtect), .hostAddrReserved(hostAddrReserved),
    .hostRdDone(hostRdDone), .hostRdAllowed(hostRdAllowed),
    .mainBlockTopAddress(mainBlockTopAddress));
`default_nettype wire

/* File: bench/host_model.sv */
// Host model: turns bench commands into one-cycle host requests.
// Assumes commands change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Command: 1 read, 2 write, 3 flag write
    input wire logic clk,
    input wire logic [1:0] cmd,
    input wire logic [20:0] cmdAddr,
    input wire logic [1:0] cmdProt,
    // Host requests
    output logic hostRdReq,
    output logic hostWrReq,
    output logic hostSemWr,
    output logic [20:0] hostRdAddr,
    output logic [1:0] hostQual,
    output logic [3:0] hostSemWrData
);
    initial {hostRdReq, hostWrReq, hostSemWr, hostRdAddr, hostQual, hostSemWrData} = '0;
    // Idle address, qualifier and data lines toggle so no stale request value can be mistaken for a new one
    always @(posedge clk) begin
        hostRdReq <= cmd == 2'h1;
        hostWrReq <= cmd == 2'h2;
        hostSemWr <= cmd == 2'h3;
        hostRdAddr <= (cmd != 2'h0) ? cmdAddr : ~hostRdAddr;
        hostQual <= (cmd != 2'h0) ? cmdProt : ~hostQual;
        hostSemWrData <= (cmd == 2'h3) ? cmdAddr[3:0] : ~hostSemWrData;
    end
endmodule // host_model
`default_nettype wire

/* File: bench/test_shared_memory_read_protect.sv */
// Bench for the shared-memory read-protect block with a host model.
// Assumes boot sizes 16K core and 64K host, flash of two 64K units.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin badCount++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_shared_memory_read_protect
    import smrp_pkg::*;
;
    localparam logic [5:0] OK = 6'h20, LW = 6'h10, ZR = 6'h08, ES = 6'h04, WI = 6'h02;
    logic clk, rst, porRst, ftz, wr1, rd1, rdPend, rdDone, ok, lw, zr, es, wrDone, wi, we;
    logic semWr, rdReq, wrReq;
    logic [1:0] env, cmd, cmdProt, qual;
    logic [15:0] ra, wd, rdat, ex;
    logic [20:0] cmdAddr, hAddr;
    logic [3:0] semData;
    logic [7:0] sem;
    logic [21:0] top;
    logic [5:0] ev;
    logic [15:0] rq[$];
    logic [5:0] vq[$];
    logic [5:0] tbl[4] = '{LW, ZR, ES, 6'h00};
    int badCount, nChecks;
    shared_memory_read_protect uut (.clk(clk), .rst(rst), .porRst(porRst), .envPins(env),
        .forceTopZero(ftz), .coreBootRegionSize(22'h004000), .hostBootRegionSize(22'h010000),
        .regAddr(ra), .regWrData(wd), .regWr(wr1), .regRd(rd1), .regRdData(rdat),
        .hostSemWr(semWr), .hostSemWrData(semData), .hostSemRdData(sem), .hostRdReq(rdReq),
        .hostRdAddr(hAddr), .hostRdProtect(qual[0]), .hostAddrReserved(qual[1]),
        .hostRdDone(rdDone), .hostRdAllowed(ok), .hostRdLongWait(lw), .hostRdZero(zr),
        .hostRdErrSync(es), .hostWrReq(wrReq), .hostWrBlocked(qual[0]), .hostWrDone(wrDone),
        .hostWrIgnored(wi), .hostWrErrSync(we), .mainBlockTopAddress(top));
    host_model host (.clk(clk), .cmd(cmd), .cmdAddr(cmdAddr), .cmdProt(cmdProt),
        .hostRdReq(rdReq), .hostWrReq(wrReq), .hostSemWr(semWr), .hostRdAddr(hAddr),
        .hostQual(qual), .hostSemWrData(semData));
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr1 <= 1'b1;
        @(posedge clk);
        wr1 <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        ra <= a;
        rd1 <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd1 <= 1'b0;
    endtask
    task automatic hc(input logic [1:0] c, input logic [20:0] a, input logic [1:0] p,
            input logic [5:0] e);
        @(posedge clk);
        cmd <= c;
        cmdAddr <= a;
        cmdProt <= p;
        if (c != 2'h3) vq.push_back(e);
        @(posedge clk);
        cmd <= 2'h0;
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) rdPend <= rd1;
    // Results are taken mid-cycle, once the launching edge has settled
    always @(negedge clk) begin
        if (rdPend === 1'b1) begin
            ex = rq.pop_front();
            `CHK("read data", ex, rdat)
        end
        if (rdDone === 1'b1 || wrDone === 1'b1) begin
            ev = vq.pop_front();
            `CHK("verdict", ev, {ok, lw, zr, es, wi, we})
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        badCount++;
        finalReport();
    end
    initial begin
        void'($urandom(32'h21a60335));
        {rst, porRst, ftz, wr1, rd1, cmd, cmdProt, env} = 11'b11000000010;
        {ra, wd, cmdAddr, badCount, nChecks} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        porRst <= 1'b0;
        rd(ADDR_MAIN_TOP, 16'h0002);
        `CHK("top", 22'h020000, top)
        rd(ADDR_SEMAPHORE, 16'h0000);
        rd(ADDR_OVR_LOW, 16'h00ff);
        rd(ADDR_OVR_MID, 16'hfffc);
        rd(ADDR_OVR_HIGH, 16'hffff);
        rd(16'hf906, 16'h0000);
        wr(ADDR_OVR_LOW, 16'h0000);
        wr(ADDR_OVR_MID, 16'h0000);
        rd(ADDR_OVR_LOW, 16'h0083);
        rd(ADDR_OVR_MID, 16'h0000);
        hc(2'h1, 21'h004000, 2'h0, OK);
        hc(2'h1, 21'h004000, 2'h1, LW);
        hc(2'h1, 21'h000000, 2'h0, LW);
        hc(2'h1, 21'h00dfff, 2'h0, OK);
        hc(2'h1, 21'h00e000, 2'h0, LW);
        hc(2'h1, 21'h01ffff, 2'h0, OK);
        hc(2'h1, 21'h030000, 2'h0, OK);
        rd(ADDR_CTRL_STATUS, 16'h0001);
        wr(ADDR_CTRL_STATUS, 16'h0001);
        rd(ADDR_CTRL_STATUS, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_STATUS, 16'(i) << 3);
            hc(2'h1, 21'h000000, 2'h0, tbl[i]);
            hc(2'h2, 21'h000000, 2'h1, (i == 2) ? 6'h01 : WI);
            hc(2'h2, 21'h004000, 2'h0, 6'h00);
        end
        wr(ADDR_CTRL_STATUS, 16'h0008);
        hc(2'h1, 21'h004000, 2'h2, ZR);
        hc(2'h3, 21'h00000a, 2'h0, 6'h00);
        rd(ADDR_SEMAPHORE, 16'h000a);
        rd(ADDR_CTRL_STATUS, 16'h0049);
        wr(ADDR_SEMAPHORE, 16'h00f5);
        rd(ADDR_SEMAPHORE, 16'h00fa);
        `CHK("host semaphores", 8'hfa, sem)
        repeat (8) hc(2'h1, 21'h004000 + 21'($urandom % 32'ha000), 2'h0, OK);
        wr(ADDR_MAIN_TOP, 16'h0003);
        rd(ADDR_OVR_LOW, 16'hffff);
        rd(ADDR_OVR_MID, 16'hfff8);
        env <= 2'h0;
        repeat (3) @(posedge clk);
        wr(ADDR_MAIN_TOP, 16'h0005);
        rd(ADDR_MAIN_TOP, 16'h0003);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_MAIN_TOP, 16'h0003);
        rd(ADDR_SEMAPHORE, 16'h0000);
        ftz <= 1'b1;
        porRst <= 1'b1;
        @(posedge clk);
        porRst <= 1'b0;
        rd(ADDR_MAIN_TOP, 16'h0000);
        for (int i = 0; i < 20 && rq.size() + vq.size() > 0; i++) @(posedge clk);
        if (rq.size() + vq.size() > 0) badCount++;
        finalReport();
    end
endmodule // test_shared_memory_read_protect
`default_nettype wire
